/* File: sim/five_pin_io_port_bench.sv */
// Self-checking bench for the five-pin configurable I/O port
`timescale 1ns/1ps
module five_pin_io_port_bench;
   import gpio_port_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   bus_req_t busReq = '0;
   logic [7:0] busRdata;
   logic [4:0] pinIn = 5'h00;
   logic [4:0] pinOut;
   logic [4:0] pinOe;
   logic downloadActive = 1'b0;
   logic downloadTx = 1'b0;
   logic serialRx = 1'b1;
   logic downloadRx;
   logic adcStart;
   logic [7:0] adcData = 8'h00;
   logic adcDone = 1'b0;
   logic analogSel;
   int errorCnt = 0;
   int nCompared = 0;

   five_pin_io_port #(.ADC_WIDTH(8)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .downloadActive(downloadActive),
      .downloadTx(downloadTx), .serialRx(serialRx), .downloadRx(downloadRx),
      .adcStart(adcStart), .adcData(adcData), .adcDone(adcDone), .analogSel(analogSel)
   );

   always #20 ref_clk = ~ref_clk;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errorCnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Outputs are sampled 1 ns after the edge that takes the write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      busReq.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      busReq.rd <= 1'b0;
      #1;
      d = busRdata;
   endtask

   function automatic logic [7:0] cmd(input op_t op, input int pin);
      return {1'b0, op, 1'b0, 3'(pin)};
   endfunction

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      logic [7:0] d;
      chk("oe", {3'h0, pinOe}, 8'h01);
      chk("out", {3'h0, pinOut}, 8'h00);
      chk("asel", {7'h00, analogSel}, 8'h01);
      rd(OFF_DIR, d);
      chk("dir", d, 8'h01);
      @(posedge ref_clk);
      #1;
      chk("rdata one cycle", busRdata, 8'h00);
      pinIn <= 5'h0A;
      rd(OFF_IN, d);
      chk("in", d, 8'h0A);
      rd(4'hF, d);
      chk("unmapped", d, 8'h00);
   endtask

   task automatic t_dirword();
      logic [7:0] w[4] = '{8'hFF, 8'h00, 8'h08, 8'hE6};
      logic [4:0] e[4] = '{5'h17, 5'h01, 5'h01, 5'h07};
      for (int i = 0; i < 4; i++) begin
         wr(OFF_DIR, w[i]);
         chk("oe word", {3'h0, pinOe}, {3'h0, e[i]});
         chk("asel word", {7'h00, analogSel}, {7'h00, ~e[i][1]});
      end
   endtask

   task automatic t_cmds();
      logic [7:0] d;
      logic [7:0] c[9];
      logic [4:0] eo[9] = '{5'h03, 5'h07, 5'h07, 5'h07, 5'h17, 5'h13, 5'h13, 5'h13, 5'h13};
      logic [4:0] ev[9] = '{5'h02, 5'h06, 5'h02, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
      c = '{cmd(OP_OUTPUT, 1), cmd(OP_HIGH, 2), cmd(OP_TOGGLE, 2), cmd(OP_LOW, 1),
            cmd(OP_DRIVE, 4), cmd(OP_INPUT, 2), cmd(OP_INPUT, 0), cmd(OP_OUTPUT, 3),
            cmd(OP_NONE, 4)};
      wr(OFF_DIR, 8'h00);
      wr(OFF_OUT, 8'h02);
      chk("out only", {3'h0, pinOe}, 8'h01);
      rd(OFF_OUT, d);
      chk("out reg", d, 8'h02);
      for (int i = 0; i < 9; i++) begin
         wr(OFF_CMD, c[i]);
         chk("oe cmd", {3'h0, pinOe}, {3'h0, eo[i]});
         chk("out cmd", {3'h0, pinOut}, {3'h0, ev[i]});
      end
      rd(OFF_DIR, d);
      chk("dir shared", d, 8'h13);
   endtask

   task automatic t_adc();
      logic [7:0] d;
      int n;
      wr(OFF_DIR, 8'h06);
      chk("asel off", {7'h00, analogSel}, 8'h00);
      wr(OFF_CMD, cmd(OP_ADC, 2));
      chk("adc other pin", {3'h0, pinOe}, 8'h07);
      wr(OFF_CMD, cmd(OP_ADC, 1));
      chk("adc oe", {3'h0, pinOe}, 8'h05);
      chk("adc asel", {7'h00, analogSel}, 8'h01);
      n = 0;
      while (adcStart !== 1'b1 && n < 10) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("start seen", {7'h00, adcStart}, 8'h01);
      @(posedge ref_clk);
      #1;
      chk("start pulse", {7'h00, adcStart}, 8'h00);
      rd(OFF_STAT, d);
      chk("adc busy", d, 8'h01);
      @(posedge ref_clk);
      adcDone <= 1'b1;
      adcData <= 8'hA5;
      @(posedge ref_clk);
      adcDone <= 1'b0;
      rd(OFF_ADC, d);
      chk("adc result", d, 8'hA5);
   endtask

   task automatic t_download();
      logic [7:0] d;
      wr(OFF_OUT, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         downloadActive <= 1'b1;
         downloadTx <= i[0];
         serialRx <= ~i[0];
         #1;
         chk("tx pin", {7'h00, pinOut[0]}, {7'h00, i[0]});
         chk("tx oe", {7'h00, pinOe[0]}, 8'h01);
         chk("rx line", {7'h00, downloadRx}, {7'h00, ~i[0]});
      end
      rd(OFF_STAT, d);
      chk("stat download", d, 8'h02);
      @(posedge ref_clk);
      downloadActive <= 1'b0;
      wr(OFF_OUT, 8'h01);
      chk("pin0 normal", {7'h00, pinOut[0]}, 8'h01);
   endtask

   // A second reset in mid-run must bring back the power-up directions
   task automatic t_rerun();
      logic [7:0] d;
      wr(OFF_DIR, 8'h16);
      chk("oe before reset", {3'h0, pinOe}, 8'h17);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("oe after reset", {3'h0, pinOe}, 8'h01);
      chk("out after reset", {3'h0, pinOut}, 8'h00);
      chk("asel after reset", {7'h00, analogSel}, 8'h01);
      rd(OFF_DIR, d);
      chk("dir after reset", d, 8'h01);
   endtask

   // ****************************************
   // Sequence, watchdog and verdict
   // ****************************************
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      t_reset();
      t_dirword();
      t_cmds();
      t_adc();
      t_download();
      t_rerun();
      give_verdict();
   end

   // The whole sequence needs well under 300 cycles
   initial begin
      repeat (3000) @(posedge ref_clk);
      errorCnt++;
      give_verdict();
   end
endmodule

/* File: src/five_pin_io_port.sv */
// Five-pin configurable I/O port with shared direction state
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module five_pin_io_port
   import gpio_port_pkg::*;
#(
   parameter int ADC_WIDTH = 8
) (
   input wire logic ref_clk, // Device clock, 25 MHz
   input wire logic rst_n, // Async reset, active low
   input wire gpio_port_pkg::bus_req_t busReq, // Register request
   output logic [7:0] busRdata, // Read data, cycle after read
   input wire logic [4:0] pinIn, // Pin input levels
   output logic [4:0] pinOut, // Pin output levels
   output logic [4:0] pinOe, // Pin output enables
   input wire logic downloadActive, // Program download in progress
   input wire logic downloadTx, // Download transmit data
   input wire logic serialRx, // Dedicated download receive line
   output logic downloadRx, // Receive line to download logic
   output logic adcStart, // Converter start pulse
   input wire logic [ADC_WIDTH-1:0] adcData, // Converter result
   input wire logic adcDone, // Converter result valid
   output logic analogSel // Pin 1 routed to converter
);
   import gpio_port_pkg::*;

   // ****************************************
   // Command decode
   // ****************************************
   logic wrDir;
   logic wrOut;
   logic wrCmd;
   logic [2:0] cmdPin;
   op_t cmdOp;
   logic [4:0] pinHit;
   logic [4:0] dirWr;
   logic [4:0] dirVal;
   logic [4:0] lvlWr;
   logic [4:0] lvlVal;
   logic [4:0] dir;
   logic [4:0] lvl;
   adc_state_t adcState;
   adc_state_t next_adcState;
   logic [ADC_WIDTH-1:0] adcResult;

   assign wrDir = busReq.wr && (busReq.addr == OFF_DIR);
   assign wrOut = busReq.wr && (busReq.addr == OFF_OUT);
   assign wrCmd = busReq.wr && (busReq.addr == OFF_CMD);
   assign cmdPin = busReq.wdata[CMD_PIN_LSB +: 3];
   assign cmdOp = op_t'(busReq.wdata[CMD_OP_LSB +: 3]);

   // Pin numbers beyond the port leave the mask empty, so the command does nothing
   always_comb begin
      pinHit = '0;
      if (cmdPin < 3'(NUM_PINS)) begin
         pinHit[cmdPin] = 1'b1;
      end
   end

   // All three methods meet in one direction/level per pin
   always_comb begin
      dirWr = '0;
      dirVal = '0;
      lvlWr = '0;
      lvlVal = lvl;
      if (wrDir) begin
         dirWr = CFG_MASK;
         dirVal = busReq.wdata[4:0];
      end else if (wrCmd) begin
         case (cmdOp)
            OP_HIGH: begin
               dirWr = pinHit;
               dirVal = '1;
               lvlWr = pinHit;
               lvlVal = lvl | pinHit;
            end
            OP_LOW: begin
               dirWr = pinHit;
               dirVal = '1;
               lvlWr = pinHit;
               lvlVal = lvl & ~pinHit;
            end
            OP_TOGGLE: begin
               dirWr = pinHit;
               dirVal = '1;
               lvlWr = pinHit;
               lvlVal = lvl ^ pinHit;
            end
            OP_DRIVE: begin
               dirWr = pinHit;
               dirVal = '1;
            end
            OP_OUTPUT: begin
               dirWr = pinHit & CFG_MASK;
               dirVal = '1;
            end
            OP_INPUT: begin
               dirWr = pinHit & CFG_MASK;
               dirVal = '0;
            end
            OP_ADC: begin
               dirWr = pinHit & 5'(1 << PIN_ADC);
               dirVal = '0;
            end
            default: begin
               dirWr = '0;
            end
         endcase
      end else if (wrOut) begin
         lvlWr = '1;
         lvlVal = busReq.wdata[4:0];
      end
   end

   // ****************************************
   // Pin cells
   // ****************************************
   // Fixed directions live in the cell, so no decode path can move them
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         io_pin_cell #(
            .FIXED_OUT(gi == PIN_TX),
            .FIXED_IN(gi == PIN_IN),
            .DIR_INIT(DIR_RESET[gi])
         ) u_cell (
            .clk(ref_clk),
            .rstN(rst_n),
            .dirWr(dirWr[gi]),
            .dirVal(dirVal[gi]),
            .lvlWr(lvlWr[gi]),
            .lvlVal(lvlVal[gi]),
            .dir(dir[gi]),
            .lvl(lvl[gi])
         );
      end
   endgenerate

   // Pin 0 follows the download stream only while it runs
   always_comb begin
      pinOut = lvl;
      pinOe = dir;
      if (downloadActive) begin
         pinOut[PIN_TX] = downloadTx;
      end
   end

   // The receive line never enters the port bit map
   assign downloadRx = serialRx;

   // ****************************************
   // Analogue sampling
   // ****************************************
   // Wait one cycle after the direction change so the pin is released first
   always_comb begin
      case (adcState)
         ADC_IDLE: begin
            next_adcState = (wrCmd && cmdOp == OP_ADC && cmdPin == 3'(PIN_ADC))
               ? ADC_SETUP : ADC_IDLE;
         end
         ADC_SETUP: begin
            next_adcState = ADC_TAKE;
         end
         ADC_TAKE: begin
            next_adcState = adcDone ? ADC_IDLE : ADC_TAKE;
         end
         default: begin
            next_adcState = ADC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         adcState <= ADC_IDLE;
      end else begin
         adcState <= next_adcState;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         adcStart <= 1'b0;
      end else begin
         adcStart <= (adcState == ADC_SETUP);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         adcResult <= ADC_WIDTH'(ADC_RESET);
      end else if (adcState == ADC_TAKE && adcDone) begin
         adcResult <= adcData;
      end
   end

   // Analogue use holds while pin 1 is an input
   assign analogSel = !dir[PIN_ADC];

   // ****************************************
   // Register read
   // ****************************************
   // Zero between reads so a stale word is never taken for an answer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdata <= 8'h00;
      end else if (busReq.rd) begin
         case (busReq.addr)
            OFF_DIR: busRdata <= {3'h0, dir};
            OFF_OUT: busRdata <= {3'h0, lvl};
            OFF_IN: busRdata <= {3'h0, pinIn};
            OFF_ADC: busRdata <= 8'(adcResult);
            OFF_STAT: busRdata <= {6'h00, downloadActive, adcState != ADC_IDLE};
            default: busRdata <= 8'h00;
         endcase
      end else begin
         busRdata <= 8'h00;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   // Direction state
   fixed_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pinOe[PIN_TX] && !pinOe[PIN_IN]) else $error("fixed pin direction lost");
   dir_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrDir |=> (dir & CFG_MASK) == ($past(busReq.wdata[4:0]) & CFG_MASK))
      else $error("direction word not applied");
   dir_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrDir |=> dir[PIN_TX] && !dir[PIN_IN]) else $error("ignored bits took effect");
   word_asel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrDir && !busReq.wdata[PIN_ADC]) |=> analogSel)
      else $error("analogue select missing after input");
   out_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wrOut |=> dir == $past(dir)) else $error("level write moved a direction");

   // Level, drive and direction commands
   set_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_LOW && cmdPin == 3'h1) |=> pinOe[1] && !pinOut[1])
      else $error("set low failed");
   drive_out_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_HIGH && cmdPin == 3'h2) |=> pinOe[2] && pinOut[2])
      else $error("set high failed");
   toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_TOGGLE && cmdPin == 3'h2)
      |=> pinOe[2] && lvl[2] != $past(lvl[2])) else $error("toggle failed");
   drive_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_DRIVE && cmdPin == 3'h4) |=> pinOe[4] && $stable(lvl))
      else $error("drive command failed");
   out_cmd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_OUTPUT && cmdPin == 3'h1) |=> dir[1] && $stable(lvl))
      else $error("make output touched level");
   in_cmd_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_INPUT && cmdPin == 3'h2) |=> !pinOe[2])
      else $error("make input failed");

   // Converter
   adc_cfg_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_ADC && cmdPin == 3'h1) |=> analogSel ##1 adcStart && analogSel)
      else $error("sample before analogue setup");
   adc_other_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wrCmd && cmdOp == OP_ADC && cmdPin != 3'(PIN_ADC)) |=> $stable(dir))
      else $error("sample on other pin changed direction");
   start_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      adcStart |=> !adcStart) else $error("start pulse too long");
   adc_store_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (adcState == ADC_TAKE && adcDone) |=> adcResult == $past(adcData))
      else $error("converter result not stored");

   // Download line
   dl_tx_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      downloadActive |-> pinOut[PIN_TX] == downloadTx) else $error("download not on pin 0");
   dl_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !downloadActive |-> pinOut[PIN_TX] == lvl[PIN_TX])
      else $error("pin 0 not a normal output");

   // ****************************************
   // Coverage
   // ****************************************
   cov_adc_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      adcStart ##[1:20] adcDone);
   cov_word_c: cover property (@(posedge ref_clk) disable iff (!rst_n) wrDir);
   cov_toggle_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      wrCmd && cmdOp == OP_TOGGLE);
   cov_input_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      wrCmd && cmdOp == OP_INPUT);
   cov_dl_end_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(downloadActive));

endmodule

/* File: src/gpio_port_pkg.sv */
// Package: constants and carrier types for the five-pin configurable port
package gpio_port_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] OFF_DIR = 4'h0;
   localparam logic [3:0] OFF_OUT = 4'h1;
   localparam logic [3:0] OFF_CMD = 4'h2;
   localparam logic [3:0] OFF_IN = 4'h3;
   localparam logic [3:0] OFF_ADC = 4'h4;
   localparam logic [3:0] OFF_STAT = 4'h5;

   // ****************************************
   // Pin layout
   // ****************************************
   localparam int NUM_PINS = 5;
   localparam int PIN_TX = 0;
   localparam int PIN_ADC = 1;
   localparam int PIN_IN = 3;
   localparam logic [4:0] CFG_MASK = 5'h16;
   localparam logic [4:0] DIR_RESET = 5'h01;
   localparam logic [4:0] OUT_RESET = 5'h00;
   localparam logic [7:0] ADC_RESET = 8'h00;

   // ****************************************
   // Command word: bits 2:0 pin, bits 6:4 opcode
   // ****************************************
   localparam int CMD_PIN_LSB = 0;
   localparam int CMD_OP_LSB = 4;
   localparam int STAT_ANA_BIT = 0;
   localparam int STAT_DL_BIT = 1;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_HIGH = 3'h1,
      OP_LOW = 3'h2,
      OP_TOGGLE = 3'h3,
      OP_DRIVE = 3'h4,
      OP_OUTPUT = 3'h5,
      OP_INPUT = 3'h6,
      OP_ADC = 3'h7
   } op_t;

   typedef enum logic [1:0] {
      ADC_IDLE = 2'b00,
      ADC_SETUP = 2'b01,
      ADC_TAKE = 2'b11
   } adc_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic [4:0] in;
      logic [4:0] out;
      logic [4:0] oe;
   } pin_bus_t;

endpackage

/* File: src/io_pin_cell.sv */
// One port pin: direction bit and output level register
`timescale 1ns/1ps
module io_pin_cell #(
   parameter bit FIXED_OUT = 1'b0,
   parameter bit FIXED_IN = 1'b0,
   parameter bit DIR_INIT = 1'b0
) (
   input wire logic clk, // Device clock
   input wire logic rstN, // Async reset, active low
   input wire logic dirWr, // Direction load strobe
   input wire logic dirVal, // Direction value, 1 output
   input wire logic lvlWr, // Level load strobe
   input wire logic lvlVal, // Level value
   output logic dir, // Current direction
   output logic lvl // Current driven level
);

   // Fixed pins ignore every direction load
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         dir <= DIR_INIT;
      end else if (FIXED_OUT) begin
         dir <= 1'b1;
      end else if (FIXED_IN) begin
         dir <= 1'b0;
      end else if (dirWr) begin
         dir <= dirVal;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         lvl <= 1'b0;
      end else if (lvlWr && !FIXED_IN) begin
         lvl <= lvlVal;
      end
   end

endmodule
